// ===== hdl/dtc_top.sv
// transfer crossbar: request queues, queue register sets, arbiters
module dtc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];     // storage words
  logic [PTW-1:0]   wptr;            // write pointer
  logic [PTW-1:0]   rptr;            // read pointer
  logic [PTW:0]     fill;            // words held
  logic [PTW-1:0]   next_wptr;
  logic [PTW-1:0]   next_rptr;
  logic [PTW:0]     next_fill;
  logic             push;
  logic             pop;

  // honest flags straight from the fill count
  // full compare kept at pointer width plus one, so depth itself fits
  assign in_ready  = (fill != (PTW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and fill arithmetic
  always_comb begin
    next_wptr = push ? ((wptr == PTW'(DEPTH - 1)) ? '0 : wptr + 1'b1)
                     : wptr;
    next_rptr = pop ? ((rptr == PTW'(DEPTH - 1)) ? '0 : rptr + 1'b1)
                    : rptr;
    next_fill = fill;
    if (push && !pop) begin
      next_fill = fill + 1'b1;
    end else if (pop && !push) begin
      next_fill = fill - 1'b1;
    end
  end

  // pointer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
      fill <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      fill <= next_fill;
    end
  end

  // storage carries no reset, so it may map onto ram
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end
endmodule

module dtc_top #(
  parameter int DEPTH = 8
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    four_queue_mode,
  input  wire logic [dtc_pkg::QW-1:0]  cache_config_reg,
  input  wire logic                    req_valid,
  output logic                         req_ready,
  input  wire logic [2:0]              req_priority_code,
  input  wire logic                    req_host,
  input  wire logic                    req_cache,
  input  wire logic [dtc_pkg::AW-1:0]  req_src,
  input  wire logic [dtc_pkg::AW-1:0]  req_dst,
  input  wire logic [dtc_pkg::CW-1:0]  req_count,
  input  wire logic [dtc_pkg::PW-1:0]  req_src_port,
  input  wire logic [dtc_pkg::PW-1:0]  req_dst_port,
  output logic                         pw_valid,
  output logic      [dtc_pkg::QW-1:0]  pw_queue,
  output logic      [dtc_pkg::PW-1:0]  pw_port,
  output logic      [dtc_pkg::AW-1:0]  pw_addr,
  output logic      [dtc_pkg::CW-1:0]  pw_len,
  input  wire logic                    ack_valid,
  input  wire logic [dtc_pkg::QW-1:0]  ack_queue,
  output logic                         rc_valid,
  output logic      [dtc_pkg::QW-1:0]  rc_queue,
  output logic      [dtc_pkg::PW-1:0]  rc_port,
  output logic      [dtc_pkg::AW-1:0]  rc_addr,
  output logic      [dtc_pkg::CW-1:0]  rc_len,
  input  wire logic [dtc_pkg::NPORT-1:0]                  rd_valid,
  input  wire logic [dtc_pkg::NPORT-1:0][dtc_pkg::DW-1:0] rd_data,
  input  wire logic [dtc_pkg::NPORT-1:0][dtc_pkg::QW-1:0] rd_queue,
  output logic      [dtc_pkg::NPORT-1:0]                  rd_ready,
  output logic                         wb_valid,
  output logic      [dtc_pkg::QW-1:0]  wb_queue,
  output logic      [dtc_pkg::PW-1:0]  wb_port,
  output logic      [dtc_pkg::AW-1:0]  wb_addr,
  output logic      [dtc_pkg::DW-1:0]  wb_data,
  output logic                         wb_last,
  output logic      [dtc_pkg::NQ-1:0]  busy
);
  import dtc_pkg::*;

  // lowest index is the highest priority queue
  function automatic logic [NQ-1:0] pick(input logic [NQ-1:0] r);
    pick = r & (~r + 1'b1);
  endfunction

  // index of a one-hot grant
  function automatic logic [QW-1:0] idx(input logic [NQ-1:0] g);
    idx = '0;
    for (int i = 0; i < NQ; i++) begin
      if (g[i]) begin
        idx = QW'(i);
      end
    end
  endfunction

  // burst bounded by both ports and by the remainder
  function automatic logic [CW-1:0] burst(input logic [CW-1:0] rem,
                                         input logic [PW-1:0] sp,
                                         input logic [PW-1:0] dp);
    logic [CW-1:0] b;
    b = port_burst(sp);
    if (port_burst(dp) < b) begin
      b = port_burst(dp);
    end
    burst = (rem < b) ? rem : b;
  endfunction

  // cache traffic urgent or configured queue
  // queue selection by variant and priority code
  function automatic logic [QW-1:0] route(input logic [2:0] priority_code,
                                         input logic host,
                                         input logic cache,
                                         input logic four,
                                         input logic [QW-1:0] csel);
    if (four) begin
      if (cache) begin
        route = csel;
      end else if (host) begin
        route = Q_TWO;
      end else begin
        route = priority_code[QW-1:0];
      end
    end else begin
      if (cache) begin
        route = Q_URGENT;
      end else if (host || priority_code == PRI_HIGH) begin
        route = Q_HIGH;
      end else begin
        route = Q_TWO;
      end
    end
  endfunction

  // request queue plumbing
  logic [QW-1:0]         tgt;       // queue picked for incoming request
  logic [RQW-1:0]        req_word;  // packed request
  logic [NQ-1:0]         in_rdy;    // room in each queue
  logic [NQ-1:0]         hv;        // head valid per queue
  logic [NQ-1:0]         pop;       // head taken into register set
  logic [NQ-1:0][RQW-1:0] head;     // head word per queue

  // queue register sets, invisible to software
  dtc_state_e          st       [NQ];
  dtc_state_e          next_st  [NQ];
  logic [AW-1:0]       src      [NQ];
  logic [AW-1:0]       next_src [NQ];
  logic [AW-1:0]       dst      [NQ];
  logic [AW-1:0]       next_dst [NQ];
  logic [CW-1:0]       cnt      [NQ];
  logic [CW-1:0]       next_cnt [NQ];
  logic [CW-1:0]       blen     [NQ];
  logic [CW-1:0]       next_blen[NQ];
  logic [CW-1:0]       beat     [NQ];
  logic [CW-1:0]       next_beat[NQ];
  logic [PW-1:0]       sp       [NQ];
  logic [PW-1:0]       next_sp  [NQ];
  logic [PW-1:0]       dp       [NQ];
  logic [PW-1:0]       next_dp  [NQ];

  // arbitration
  logic [NQ-1:0]       pw_req;   // queues wanting pre-write pipeline
  logic [NQ-1:0]       rc_req;   // queues wanting read pipeline
  logic [NQ-1:0]       wb_req;   // queues with read data waiting
  logic [NQ-1:0]       pw_gnt;
  logic [NQ-1:0]       rc_gnt;
  logic [NQ-1:0]       wb_gnt;
  logic [QW-1:0]       pw_i;
  logic [QW-1:0]       rc_i;
  logic [QW-1:0]       wb_i;

  assign tgt = route(req_priority_code, req_host, req_cache,
                     four_queue_mode, cache_config_reg);
  assign req_word  = {req_src, req_dst, req_count, req_src_port,
                      req_dst_port};
  // back-pressure: a full target queue stalls the requester
  assign req_ready = in_rdy[tgt];

  // one request queue per priority level
  for (genvar q = 0; q < NQ; q++) begin : g_q
    dtc_fifo #(
      .WIDTH (RQW),
      .DEPTH (DEPTH)
    ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (req_valid && tgt == QW'(q)),
      .in_ready  (in_rdy[q]),
      .in_data   (req_word),
      .out_valid (hv[q]),
      .out_ready (pop[q]),
      .out_data  (head[q])
    );
  end

  // request vectors for the three arbiters
  always_comb begin
    for (int q = 0; q < NQ; q++) begin
      pw_req[q] = (st[q] == ST_PREW);
      rc_req[q] = (st[q] == ST_READ);
      wb_req[q] = (st[q] == ST_DATA) && rd_valid[sp[q]]
                  && rd_queue[sp[q]] == QW'(q);
    end
  end

  assign pw_gnt = pick(pw_req);
  assign rc_gnt = pick(rc_req);
  // highest priority ready data takes the write bus
  assign wb_gnt = pick(wb_req);
  assign pw_i   = idx(pw_gnt);
  assign rc_i   = idx(rc_gnt);
  assign wb_i   = idx(wb_gnt);

  // source port handshake: only the winner's port is drained
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      rd_ready[p] = (|wb_gnt) && sp[wb_i] == PW'(p);
    end
  end

  // queue register set sequencing
  always_comb begin
    for (int q = 0; q < NQ; q++) begin
      next_st[q]   = st[q];
      next_src[q]  = src[q];
      next_dst[q]  = dst[q];
      next_cnt[q]  = cnt[q];
      next_blen[q] = blen[q];
      next_beat[q] = beat[q];
      next_sp[q]   = sp[q];
      next_dp[q]   = dp[q];
      pop[q]       = 1'b0;
      unique case (st[q])
        // take the head only when idle
        ST_IDLE: begin
          if (hv[q]) begin
            pop[q] = 1'b1;
            {next_src[q], next_dst[q], next_cnt[q], next_sp[q],
             next_dp[q]} = head[q];
            next_blen[q] = burst(next_cnt[q], next_sp[q], next_dp[q]);
            // an empty transfer is dropped at once
            next_st[q] = (next_cnt[q] == CNT_RST) ? ST_IDLE : ST_PREW;
          end
        end
        // pre-write waits for its pipeline slot
        ST_PREW: begin
          if (pw_gnt[q]) begin
            next_st[q] = ST_ACK;
          end
        end
        // hold the source free until acknowledged
        ST_ACK: begin
          if (ack_valid && ack_queue == QW'(q)) begin
            next_st[q] = ST_READ;
          end
        end
        ST_READ: begin
          if (rc_gnt[q]) begin
            next_beat[q] = CNT_RST;
            next_st[q]   = ST_DATA;
          end
        end
        // each granted beat goes out as a write
        ST_DATA: begin
          if (wb_gnt[q]) begin
            next_beat[q] = beat[q] + 1'b1;
            if (beat[q] == blen[q] - 1'b1) begin
              // count drops once the write is issued
              next_cnt[q] = cnt[q] - blen[q];
              next_src[q] = src[q] + AW'(blen[q]);
              next_dst[q] = dst[q] + AW'(blen[q]);
              next_blen[q] = burst(next_cnt[q], sp[q], dp[q]);
              next_st[q] = (next_cnt[q] == CNT_RST) ? ST_IDLE
                                                    : ST_PREW;
            end
          end
        end
      endcase
    end
  end

  // register sets update together each cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int q = 0; q < NQ; q++) begin
        st[q]   <= ST_IDLE;
        src[q]  <= ADDR_RST;
        dst[q]  <= ADDR_RST;
        cnt[q]  <= CNT_RST;
        blen[q] <= CNT_RST;
        beat[q] <= CNT_RST;
        sp[q]   <= '0;
        dp[q]   <= '0;
      end
    end else begin
      for (int q = 0; q < NQ; q++) begin
        st[q]   <= next_st[q];
        src[q]  <= next_src[q];
        dst[q]  <= next_dst[q];
        cnt[q]  <= next_cnt[q];
        blen[q] <= next_blen[q];
        beat[q] <= next_beat[q];
        sp[q]   <= next_sp[q];
        dp[q]   <= next_dp[q];
      end
    end
  end

  // command outputs, one flop stage after the grant
  logic                next_pw_valid;
  logic                next_rc_valid;
  logic                next_wb_valid;
  logic                next_wb_last;
  logic [NQ-1:0]       next_busy;

  // pre-write and read each own a pipeline
  always_comb begin
    next_pw_valid = |pw_gnt;
    next_rc_valid = |rc_gnt;
    next_wb_valid = |wb_gnt;
    next_wb_last  = (|wb_gnt) && beat[wb_i] == blen[wb_i] - 1'b1;
    for (int q = 0; q < NQ; q++) begin
      next_busy[q] = (next_st[q] != ST_IDLE);
    end
  end

  // output registers; payloads only load on a grant
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pw_valid <= 1'b0;
      pw_queue <= '0;
      pw_port  <= '0;
      pw_addr  <= ADDR_RST;
      pw_len   <= CNT_RST;
      rc_valid <= 1'b0;
      rc_queue <= '0;
      rc_port  <= '0;
      rc_addr  <= ADDR_RST;
      rc_len   <= CNT_RST;
      wb_valid <= 1'b0;
      wb_queue <= '0;
      wb_port  <= '0;
      wb_addr  <= ADDR_RST;
      wb_data  <= '0;
      wb_last  <= 1'b0;
      busy     <= '0;
    end else begin
      pw_valid <= next_pw_valid;
      rc_valid <= next_rc_valid;
      wb_valid <= next_wb_valid;
      wb_last  <= next_wb_last;
      busy     <= next_busy;
      if (next_pw_valid) begin
        pw_queue <= pw_i;
        pw_port  <= dp[pw_i];
        pw_addr  <= dst[pw_i];
        pw_len   <= blen[pw_i];
      end
      if (next_rc_valid) begin
        rc_queue <= rc_i;
        rc_port  <= sp[rc_i];
        rc_addr  <= src[rc_i];
        rc_len   <= blen[rc_i];
      end
      if (next_wb_valid) begin
        wb_queue <= wb_i;
        wb_port  <= dp[wb_i];
        wb_addr  <= dst[wb_i] + AW'(beat[wb_i]);
        wb_data  <= rd_data[sp[wb_i]];
      end
    end
  end
endmodule

// ===== hdl/dtc_pkg.sv
// constants, types and helpers of the transfer crossbar
// Function
// - cache requests use urgent or configured queue
// - three-queue routing by priority code
// - four-queue routing by priority code
// - one request in service per queue
// - private address and count per queue
// - bursts bounded by port and remainder
// - queues run concurrently, conflicts by priority
// - pre-write, read, write on two pipelines
// - per-pipeline priority arbitration every cycle
// - pre-write first, await destination ack
// - read only after pre-write ack
// - read data forwarded with write command
// - shared write bus, highest priority first
// - chain request beats local, except token (no chain requests here)
package dtc_pkg;
  localparam int NQ    = 4;   // queue count (four-queue variant)
  localparam int QW    = 2;   // queue index width
  localparam int NPORT = 4;   // memory/peripheral ports
  localparam int PW    = 2;   // port index width
  localparam int AW    = 32;  // address width
  localparam int CW    = 16;  // element count width
  localparam int DW    = 32;  // data width
  localparam int RQW   = 2 * AW + CW + 2 * PW; // packed request
  // priority codes
  localparam logic [2:0] PRI_URGENT = 3'h0;
  localparam logic [2:0] PRI_HIGH   = 3'h1;
  localparam logic [2:0] PRI_MED    = 3'h2;
  localparam logic [2:0] PRI_LOW    = 3'h3;
  // queue indices
  localparam logic [QW-1:0] Q_URGENT = 2'h0;
  localparam logic [QW-1:0] Q_HIGH   = 2'h1;
  localparam logic [QW-1:0] Q_TWO    = 2'h2;
  localparam logic [QW-1:0] Q_THREE  = 2'h3;
  // fixed hardware burst size of each port, in elements
  localparam logic [CW-1:0] BURST_P0 = 16'h0010;
  localparam logic [CW-1:0] BURST_P1 = 16'h0008;
  localparam logic [CW-1:0] BURST_P2 = 16'h0004;
  localparam logic [CW-1:0] BURST_P3 = 16'h0001;
  // reset values
  localparam logic [AW-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [CW-1:0] CNT_RST  = 16'h0000;
  // per-queue service states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PREW = 5'h02,
    ST_ACK  = 5'h04,
    ST_READ = 5'h08,
    ST_DATA = 5'h10
  } dtc_state_e;

  // hardware burst of one port
  function automatic logic [CW-1:0] port_burst(input logic [PW-1:0] p);
    case (p)
      2'h0:    port_burst = BURST_P0;
      2'h1:    port_burst = BURST_P1;
      2'h2:    port_burst = BURST_P2;
      default: port_burst = BURST_P3;
    endcase
  endfunction
endpackage

// ===== test/dtc_top_props.sv
// concurrent checks on the ports of the transfer crossbar
module dtc_top_chk
  import dtc_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic                        pw_valid,
  input wire logic [QW-1:0]               pw_queue,
  input wire logic [PW-1:0]               pw_port,
  input wire logic [CW-1:0]               pw_len,
  input wire logic                        ack_valid,
  input wire logic [QW-1:0]               ack_queue,
  input wire logic                        rc_valid,
  input wire logic [QW-1:0]               rc_queue,
  input wire logic [PW-1:0]               rc_port,
  input wire logic [CW-1:0]               rc_len,
  input wire logic [NPORT-1:0]            rd_valid,
  input wire logic [NPORT-1:0][DW-1:0]    rd_data,
  input wire logic [NPORT-1:0]            rd_ready,
  input wire logic                        wb_valid,
  input wire logic [QW-1:0]               wb_queue,
  input wire logic [DW-1:0]               wb_data,
  input wire logic                        wb_last,
  input wire logic [NQ-1:0]               busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [NQ-1:0]    wait_ack, got_ack, in_data;    // burst phase per queue
  logic [NQ-1:0]    next_wait_ack, next_got_ack, next_in_data;
  logic [NPORT-1:0] tk;                            // beats consumed now
  logic [DW-1:0]    tk_data;                       // data of consumed beat
  // largest burst a port may take
  function automatic logic [CW-1:0] lim(input logic [PW-1:0] p);
    return p == 2'h0 ? BURST_P0 : p == 2'h1 ? BURST_P1 :
           p == 2'h2 ? BURST_P2 : BURST_P3;
  endfunction
  // track pre-write, ack, read and write phase of every queue
  always_comb begin
    next_wait_ack = wait_ack;
    next_got_ack = got_ack;
    next_in_data = in_data;
    for (int q = 0; q < NQ; q++) begin
      if (pw_valid && pw_queue == QW'(q)) next_wait_ack[q] = 1'b1;
      if (ack_valid && ack_queue == QW'(q) && wait_ack[q]) begin
        next_wait_ack[q] = 1'b0;
        next_got_ack[q] = 1'b1;
      end
      if (rc_valid && rc_queue == QW'(q)) begin
        next_got_ack[q] = 1'b0;
        next_in_data[q] = 1'b1;
      end
      if (wb_valid && wb_last && wb_queue == QW'(q)) next_in_data[q] = 1'b0;
    end
    tk = rd_valid & rd_ready;
    tk_data = '0;
    // only one beat may be taken, so the pick order is moot
    for (int p = NPORT - 1; p >= 0; p--) if (tk[p]) tk_data = rd_data[p];
  end
  // register the phase flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_ack <= '0;
      got_ack <= '0;
      in_data <= '0;
    end else begin
      wait_ack <= next_wait_ack;
      got_ack <= next_got_ack;
      in_data <= next_in_data;
    end
  end
  chk_read_after_ack: assert property (rc_valid |-> got_ack[rc_queue])
    else $error("read command without destination ack");
  chk_prew_order: assert property (pw_valid |-> !wait_ack[pw_queue] &&
    !got_ack[pw_queue] && (!in_data[pw_queue] || (wb_valid && wb_last)))
    else $error("pre-write while previous burst unfinished");
  chk_write_in_data: assert property (wb_valid |-> in_data[wb_queue])
    else $error("write beat outside a read burst");
  chk_beat_forward: assert property ((|tk) |=> wb_valid &&
    wb_data == $past(tk_data))
    else $error("read beat not forwarded on write bus");
  chk_ready_valid: assert property ((rd_ready & ~rd_valid) == '0)
    else $error("ready on a port with no data");
  chk_one_beat: assert property ($onehot0(rd_ready))
    else $error("two read beats taken in one cycle");
  chk_busy_prew: assert property (pw_valid |-> busy[pw_queue])
    else $error("pre-write from an idle register set");
  chk_pw_len: assert property (pw_valid |-> pw_len != '0 &&
    pw_len <= lim(pw_port))
    else $error("pre-write burst length out of range");
  chk_rc_len: assert property (rc_valid |-> rc_len != '0 &&
    rc_len <= lim(rc_port))
    else $error("read burst length out of range");
endmodule

bind dtc_top dtc_top_chk u_dtc_top_chk (.*);

// ===== test/dtc_far_model.sv
// destination and source ports seen by the crossbar
module dtc_far_model
  import dtc_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     slow,
  input  wire logic                     pw_valid,
  input  wire logic [QW-1:0]            pw_queue,
  output logic                          ack_valid,
  output logic      [QW-1:0]            ack_queue,
  input  wire logic                     rc_valid,
  input  wire logic [QW-1:0]            rc_queue,
  input  wire logic [PW-1:0]            rc_port,
  input  wire logic [AW-1:0]            rc_addr,
  input  wire logic [CW-1:0]            rc_len,
  output logic      [NPORT-1:0]         rd_valid,
  output logic      [NPORT-1:0][DW-1:0] rd_data,
  output logic      [NPORT-1:0][QW-1:0] rd_queue,
  input  wire logic [NPORT-1:0]         rd_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [QW-1:0]       ackq[$];         // pre-writes awaiting ack
  logic [QW+AW+CW-1:0] rdq[NPORT][$];   // read commands per source
  logic [CW-1:0]       beat[NPORT];     // beat index of head command
  logic [NPORT-1:0]    took;            // beat consumed at last edge
  logic                tick;            // stall pattern in slow mode
  int                  dly;             // cycles the head ack waited
  // capture commands and consumed beats at the crossbar's edge
  always @(posedge clk) begin
    if (rst) took <= '0;
    else took <= rd_valid & rd_ready;
    if (pw_valid && !rst) ackq.push_back(pw_queue);
    if (rc_valid && !rst) rdq[rc_port].push_back({rc_queue, rc_addr, rc_len});
  end
  // answer off the sampling edge
  always @(negedge clk) begin
    if (rst) begin
      ack_valid = 1'b0;
      ack_queue = '0;
      rd_valid = '0;
      rd_data = '0;
      rd_queue = '0;
      beat = '{default: '0};
      dly = 0;
      tick = 1'b0;
    end else begin
      tick = ~tick;
      ack_valid = 1'b0;
      ack_queue = ~ack_queue;
      // ack once the head has waited more than 12 cycles when slow, more than 1 otherwise
      if (ackq.size() > 0) begin
        dly++;
        if (dly > (slow ? 12 : 1)) begin
          ack_valid = 1'b1;
          ack_queue = ackq.pop_front();
          dly = 0;
        end
      end
      for (int p = 0; p < NPORT; p++) begin
        if (took[p]) begin
          beat[p]++;
          if (beat[p] == rdq[p][0][CW-1:0]) begin
            void'(rdq[p].pop_front());
            beat[p] = '0;
          end
        end
        // an offered beat is held until consumed; stalls only between
        if (!rd_valid[p] || took[p])
          rd_valid[p] = rdq[p].size() > 0 && !(slow && tick);
        if (rd_valid[p]) begin
          rd_queue[p] = rdq[p][0][CW+AW +: QW];
          rd_data[p] = rdq[p][0][CW +: AW] + AW'(beat[p]);
        end else begin
          rd_queue[p] = ~rd_queue[p];
          rd_data[p] = ~rd_data[p];
        end
      end
    end
  end
endmodule

// ===== test/tb_dtc_top.sv
// self-checking bench of the transfer crossbar
module tb_dtc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dtc_pkg::*;
  localparam int DEPTH = 8;                    // request queue depth
  logic clk, rst, four_queue_mode, slow;
  logic [QW-1:0] cache_config_reg, pw_queue, rc_queue, wb_queue, ack_queue;
  logic req_valid, req_ready, req_host, req_cache, ack_valid;
  logic [2:0] req_priority_code;
  logic [AW-1:0] req_src, req_dst, pw_addr, rc_addr, wb_addr;
  logic [CW-1:0] req_count, pw_len, rc_len;
  logic [PW-1:0] req_src_port, req_dst_port, pw_port, rc_port, wb_port;
  logic pw_valid, rc_valid, wb_valid, wb_last;
  logic [NPORT-1:0] rd_valid, rd_ready;
  logic [NPORT-1:0][DW-1:0] rd_data;
  logic [NPORT-1:0][QW-1:0] rd_queue;
  logic [DW-1:0] wb_data;
  logic [NQ-1:0] busy;
  logic [66:0] exq[NQ][$];                     // expected beats per queue
  logic [66:0] e_exp;
  logic [15:0] rnd;                            // random source
  int mismatches, n_tests, cyc, acc;
  bit ok, h;

  dtc_top #(.DEPTH(DEPTH)) u_dtc_top (.*);
  dtc_far_model u_dtc_far_model (.*);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // port burst limits, from the package's constants
  function automatic logic [CW-1:0] lim(input logic [PW-1:0] p);
    return p == 2'h0 ? BURST_P0 : p == 2'h1 ? BURST_P1 :
           p == 2'h2 ? BURST_P2 : BURST_P3;
  endfunction
  // queue a request should land in
  function automatic logic [QW-1:0] qsel(input logic [2:0] priority_code,
      input logic host, input logic cache);
    if (four_queue_mode) return cache ? cache_config_reg : host ? Q_TWO : priority_code[1:0];
    return cache ? Q_URGENT : (host || priority_code == PRI_HIGH) ? Q_HIGH : Q_TWO;
  endfunction
  function automatic int pend();
    pend = 0;
    for (int q = 0; q < NQ; q++) pend += exq[q].size();
  endfunction
  task automatic fail(input string m);
    mismatches++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // offer one request; try mode gives up at once when refused
  task automatic send(input logic [2:0] priority_code, input logic host, cache,
      input logic [QW-1:0] csel, input logic [CW-1:0] cnt,
      input logic [PW-1:0] sp, dp, input bit tr, output bit got);
    logic [AW-1:0] s, d;
    logic [CW-1:0] rem, off, b;
    logic [QW-1:0] q;
    int w;
    rnd = lfsr(rnd);
    s = {16'h1000, rnd};
    rnd = lfsr(rnd);
    d = {16'h2000, rnd};
    @(negedge clk);
    {req_priority_code, req_host, req_cache, cache_config_reg} =
      {priority_code, host, cache, csel};
    {req_src, req_dst, req_count, req_src_port, req_dst_port} =
      {s, d, cnt, sp, dp};
    req_valid = 1'b1;
    w = 0;
    while (req_ready !== 1'b1 && !tr && w < 500) begin
      @(negedge clk);
      w++;
    end
    got = (req_ready === 1'b1);
    if (!got && !tr) fail("request never taken");
    // a refused try must not linger into the next edge
    if (!got) req_valid = 1'b0;
    if (got) begin
      q = qsel(priority_code, host, cache);
      @(posedge clk);
      rem = cnt;
      off = '0;
      while (rem != '0) begin
        b = rem;
        if (b > lim(sp)) b = lim(sp);
        if (b > lim(dp)) b = lim(dp);
        for (int k = 0; k < b; k++)
          exq[q].push_back({dp, AW'(d + off + k), AW'(s + off + k), k == b - 1});
        off += b;
        rem -= b;
      end
    end
  endtask
  task automatic drain;
    int w;
    @(negedge clk);
    req_valid = 1'b0;
    w = 0;
    while ((busy !== '0 || pend() != 0) && w < 30000) begin
      @(posedge clk);
      #1;
      w++;
    end
    n_tests++;
    if (busy !== '0 || pend() != 0) fail("transfers left unfinished");
  endtask
  // compare every write beat with the oldest note of its queue
  always @(negedge clk) begin
    if (!rst && wb_valid === 1'b1) begin
      n_tests++;
      if (exq[wb_queue].size() == 0) fail("beat on unexpected queue");
      else begin
        e_exp = exq[wb_queue].pop_front();
        if ({wb_port, wb_addr, wb_data, wb_last} !== e_exp)
          fail("write beat mismatch");
      end
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      fail("run did not finish");
      wrap_up;
    end
  end
  initial begin
    {rst, four_queue_mode, slow, req_valid, req_host, req_cache} = 6'h30;
    {cache_config_reg, req_priority_code, req_count} = '0;
    {req_src, req_dst, req_src_port, req_dst_port} = '0;
    {mismatches, n_tests, cyc} = '0;
    rnd = 16'h000E;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // every code, host and cache source in both maps, back to back
    for (int m = 0; m < 2; m++) begin
      @(negedge clk);
      four_queue_mode = m[0];
      for (int i = 0; i < 10; i++) begin
        rnd = lfsr(rnd);
        h = (i == 4 || i == 8);
        send(h ? (m[0] ? PRI_MED : PRI_HIGH) : {1'b0, i[1:0]}, h,
          i >= 6 && !h, rnd[7:6], i == 0 ? 16'h0011 : i == 1 ? 16'h0001 :
          i == 2 ? 16'h0000 : h ? {13'h0000, rnd[2:0]} + 16'h0001 :
          {11'h000, rnd[4:0]} + 16'h0001, i == 0 ? 2'h0 : rnd[3:2],
          i == 0 ? 2'h0 : rnd[9:8], 1'b0, ok);
      end
      drain();
    end
    // fill one queue against a stalling far side until refused
    @(negedge clk);
    slow = 1'b1;
    acc = 0;
    ok = 1'b1;
    for (int i = 0; i < 14 && ok; i++) begin
      send(PRI_LOW, 1'b0, 1'b0, 2'h0, 16'h0002, 2'h3, 2'h3, 1'b1, ok);
      if (ok) acc++;
    end
    n_tests++;
    if (acc < DEPTH || acc > DEPTH + 2) fail("queue fill level wrong");
    drain();
    wrap_up;
  end
endmodule
